// *** rtl/aggregator.sv ***
// aggregator end: six serial inputs merged onto one fast link
`timescale 1ns/10ps
`default_nettype none
module aggregator #(
  parameter int FIFO_WORDS = readout_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // serial inputs from the concentrators, idle high
  input wire logic [readout_pkg::NUM_CONC-1:0] conc_data,
  // timing inputs and their copies
  input wire logic system_timing_clock,
  input wire logic timestamp_counter_reset,
  output logic [readout_pkg::NUM_CONC-1:0] conc_timing_clock,
  output logic [readout_pkg::NUM_CONC-1:0] conc_counter_reset,
  // control paths toward the concentrators
  output logic [readout_pkg::NUM_CONC-1:0] ctrl_path_valid,
  output logic [readout_pkg::CTRL_DEST_LSB-1:0] ctrl_path_word,
  // link toward the collector
  readout_link_if.aggregator link
);
  import readout_pkg::*;

  typedef struct packed {
    logic [NUM_CONC-1:0] prev;
    logic [NUM_CONC-1:0] busy;
    logic [NUM_CONC-1:0][2:0] cnt;
    logic [NUM_CONC-1:0][4:0] bitn;
    logic [NUM_CONC-1:0][DATA_W-1:0] sh;
    logic [NUM_CONC-1:0] pend;
    logic [NUM_CONC-1:0][DATA_W-1:0] word;
    logic [SRC_W-1:0] rr;
    logic tx_busy;
    logic [3:0] beat;
    logic [LINK_W-1:0] tx_sh;
    logic [NUM_CONC-1:0] ctrl_valid;
    logic [CTRL_DEST_LSB-1:0] ctrl_word;
  } agg_state_t;
  agg_state_t s_reg, s_next;

  logic push_valid;
  logic push_ready;
  logic [LINK_W-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [LINK_W-1:0] pop_data;

  // combinational copies: plain wires with no logic, same delay every time
  assign conc_timing_clock = {NUM_CONC{system_timing_clock}}; // RULE8 RULE9 RULE19
  assign conc_counter_reset = {NUM_CONC{timestamp_counter_reset}}; // RULE8 RULE9 RULE19
  assign ctrl_path_valid = s_reg.ctrl_valid;
  assign ctrl_path_word = s_reg.ctrl_word;
  assign link.lane = s_reg.tx_sh[LANE_W-1:0];
  assign link.frame = s_reg.tx_busy;
  assign pop_ready = !s_reg.tx_busy;

  stream_fifo #(.WIDTH(LINK_W), .DEPTH(FIFO_WORDS)) merge_fifo (
    .clock(clock),
    .rst_b(rst_b),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_data),
    .out_valid(pop_valid),
    .out_ready(pop_ready),
    .out_data(pop_data)
  );

  always_comb begin
    int idx;
    logic found;
    idx = 0;
    found = 1'b0;
    s_next = s_reg;
    push_valid = 1'b0;
    push_data = '0;
    // round robin over held words; a full fifo stalls the pick
    for (int k = 0; k < NUM_CONC; k++) begin
      idx = int'(s_reg.rr) + k;
      if (idx >= NUM_CONC) begin
        idx = idx - NUM_CONC;
      end
      if (!found && s_reg.pend[idx]) begin
        found = 1'b1;
        push_valid = 1'b1;
        push_data = {1'b0, SRC_W'(idx), s_reg.word[idx]}; // RULE2
        if (push_ready) begin
          s_next.pend[idx] = 1'b0;
          s_next.rr = (idx == NUM_CONC - 1) ? '0 : SRC_W'(idx + 1);
        end
      end
    end
    // one 10 Mbit/s receiver per concentrator: start, data lsb first, stop
    s_next.prev = conc_data;
    for (int i = 0; i < NUM_CONC; i++) begin // RULE1
      if (!s_reg.busy[i]) begin
        if (s_reg.prev[i] && !conc_data[i]) begin
          s_next.busy[i] = 1'b1;
          s_next.cnt[i] = 3'(IN_MID_CYCLES);
          s_next.bitn[i] = '0;
        end
      end else if (s_reg.cnt[i] != '0) begin
        s_next.cnt[i] = s_reg.cnt[i] - 3'd1;
      end else begin
        s_next.cnt[i] = 3'(IN_BIT_CYCLES - 1); // RULE3
        s_next.bitn[i] = s_reg.bitn[i] + 5'd1;
        if (s_reg.bitn[i] == '0) begin
          // a glitch that is high at mid start bit is no frame
          s_next.busy[i] = !conc_data[i];
        end else if (s_reg.bitn[i] != 5'(IN_STOP_BIT)) begin
          s_next.sh[i] = {conc_data[i], s_reg.sh[i][DATA_W-1:1]};
        end else begin
          s_next.busy[i] = 1'b0;
          // a word still held is kept; the new one is lost on a bad stop or overrun
          if (conc_data[i] && !s_next.pend[i]) begin
            s_next.pend[i] = 1'b1;
            s_next.word[i] = s_reg.sh[i];
          end
        end
      end
    end
    // serializer: two bits per clock, one idle cycle between words
    if (s_reg.tx_busy) begin
      s_next.tx_sh = s_reg.tx_sh >> LANE_W; // RULE4
      s_next.beat = s_reg.beat + 4'd1;
      if (s_reg.beat == 4'(LINK_BEATS - 1)) begin
        s_next.tx_busy = 1'b0;
        s_next.tx_sh = '0;
      end
    end else if (pop_valid) begin
      s_next.tx_busy = 1'b1;
      s_next.tx_sh = pop_data;
      s_next.beat = '0;
    end
    // control word: route on the top field, drop it, keep the chip field
    s_next.ctrl_valid = '0;
    if (link.ctrl_valid) begin
      for (int p = 0; p < NUM_CONC; p++) begin
        if (link.ctrl_word[CTRL_W-1:CTRL_DEST_LSB] == CTRL_DEST_W'(p)) begin
          s_next.ctrl_valid[p] = 1'b1; // RULE5 RULE6
        end
      end
      s_next.ctrl_word = link.ctrl_word[CTRL_DEST_LSB-1:0]; // RULE6 RULE7
    end
    if (!rst_b) begin
      s_next = '0;
      s_next.prev = '1;
    end
  end

  always_ff @(posedge clock) begin
    s_reg <= s_next;
  end
endmodule : aggregator
`default_nettype wire

// *** rtl/readout_pkg.sv ***
// constants shared by the aggregator, the collector and their link
// Overview of operation
// RULE1: aggregator takes six concentrator input streams
// RULE2: aggregator tags each word with input link
// RULE3: concentrator input links run at 10 Mbit/s
// RULE4: aggregator output link runs at 100 Mbit/s
// RULE5: aggregator has six separate downstream control paths
// RULE6: decode destination field, route, then strip it
// RULE7: chip destination field forwarded unchanged
// RULE8: timing signals fanned out unprocessed
// RULE9: timing fan-out has fixed delay
// RULE10: data pushed unsolicited, collector never requests
// RULE11: collector deserializes bits into complete words
// RULE12: collector tags each word with link number
// RULE13: two buffers: write one, read other
// RULE14: buffers swap on each external timing tick
// RULE15: reader drains inactive buffer within period
// RULE16: collector link rate follows aggregator output
// RULE17: collector terminates twelve aggregator links
// RULE18: data links receive-only; control separate
// RULE19: forward system clock and counter reset
// RULE20: full buffer drops word, sets sticky overflow
// RULE21: buffer swap only between whole words
package readout_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int IN_RATE_BPS = 10_000_000;
  localparam int LINK_RATE_BPS = 100_000_000;
  localparam int IN_BIT_CYCLES = CLK_HZ / IN_RATE_BPS;
  localparam int IN_MID_CYCLES = IN_BIT_CYCLES / 2;
  localparam int LANE_W = LINK_RATE_BPS / CLK_HZ;
  localparam int NUM_CONC = 6;
  localparam int SRC_W = 3;
  localparam int DATA_W = 16;
  localparam int IN_STOP_BIT = DATA_W + 1;
  localparam int LINK_W = 20;
  localparam int LINK_BEATS = LINK_W / LANE_W;
  localparam int NUM_LINKS = 12;
  localparam int LINK_ID_W = 4;
  localparam int REC_W = LINK_W + LINK_ID_W;
  localparam int FIFO_DEPTH = 8;
  localparam int CTRL_W = 24;
  localparam int CTRL_DEST_W = 3;
  localparam int CTRL_DEST_LSB = CTRL_W - CTRL_DEST_W;
  localparam int CTRL_CHIP_W = 4;
  localparam int CTRL_CHIP_LSB = CTRL_DEST_LSB - CTRL_CHIP_W;
  localparam int BUF_DEPTH = 256;
endpackage : readout_pkg

// *** rtl/readout_link_if.sv ***
// link between one aggregator and one collector input
`timescale 1ns/10ps
`default_nettype none
interface readout_link_if;
  import readout_pkg::*;
  logic [LANE_W-1:0] lane;
  logic frame;
  logic ctrl_valid;
  logic [CTRL_W-1:0] ctrl_word;
  modport aggregator (output lane, output frame, input ctrl_valid, input ctrl_word);
  modport collector (input lane, input frame, output ctrl_valid, output ctrl_word);
endinterface : readout_link_if
`default_nettype wire

// *** rtl/stream_fifo.sv ***
// small valid/ready FIFO
`timescale 1ns/10ps
`default_nettype none
module stream_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
  } fifo_state_t;
  fifo_state_t s_reg, s_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic full;
  logic empty;

  // extra pointer bit tells full from empty
  assign empty = (s_reg.wr_ptr == s_reg.rd_ptr);
  assign full = (s_reg.wr_ptr[AW-1:0] == s_reg.rd_ptr[AW-1:0]) && !empty;
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[s_reg.rd_ptr[AW-1:0]];

  always_comb begin
    s_next = s_reg;
    if (in_valid && !full) begin
      s_next.wr_ptr = s_reg.wr_ptr + 1'b1;
    end
    if (out_ready && !empty) begin
      s_next.rd_ptr = s_reg.rd_ptr + 1'b1;
    end
    if (!rst_b) begin
      s_next = '0;
    end
  end

  always_ff @(posedge clock) begin
    s_reg <= s_next;
    if (in_valid && !full) begin
      mem[s_reg.wr_ptr[AW-1:0]] <= in_data;
    end
  end
endmodule : stream_fifo
`default_nettype wire

// *** rtl/collector.sv ***
// collector end: twelve receive links into ping-pong readout buffers
`timescale 1ns/10ps
`default_nettype none
module collector #(
  parameter int BUF_WORDS = readout_pkg::BUF_DEPTH
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // buffer swap tick from the timing system
  input wire logic swap_tick,
  // readout of the inactive buffer
  input wire logic [$clog2(BUF_WORDS)-1:0] rd_addr,
  output logic [readout_pkg::REC_W-1:0] rd_data,
  output logic [$clog2(BUF_WORDS):0] rd_count,
  output logic active_buf,
  // overflow flag
  output logic overflow,
  input wire logic overflow_clear,
  // control words toward the aggregators
  input wire logic ctrl_wr,
  input wire logic [readout_pkg::LINK_ID_W-1:0] ctrl_link,
  input wire logic [readout_pkg::CTRL_W-1:0] ctrl_word,
  // aggregator links
  readout_link_if.collector links [readout_pkg::NUM_LINKS]
);
  import readout_pkg::*;

  localparam int AW = $clog2(BUF_WORDS);

  typedef struct packed {
    logic [NUM_LINKS-1:0][3:0] beats;
    logic [NUM_LINKS-1:0][LINK_W-1:0] sh;
    logic [NUM_LINKS-1:0] pend;
    logic [NUM_LINKS-1:0][LINK_W-1:0] word;
    logic [LINK_ID_W-1:0] rr;
    logic active;
    logic [AW:0] wr_cnt;
    logic [AW:0] done_cnt;
    logic ovf;
    logic [REC_W-1:0] rd_data;
    logic [NUM_LINKS-1:0] ctrl_valid;
    logic [CTRL_W-1:0] ctrl_word;
  } col_state_t;
  col_state_t s_reg, s_next;

  // both buffers in one array; the top address bit picks the buffer
  logic [REC_W-1:0] mem [2*BUF_WORDS];

  logic [NUM_LINKS-1:0][LANE_W-1:0] lane_in;
  logic [NUM_LINKS-1:0] frame_in;
  logic wr_en;
  logic [AW:0] wr_addr;
  logic [REC_W-1:0] wr_data;

  // links only carry data inward; control leaves on its own wires
  for (genvar g = 0; g < NUM_LINKS; g++) begin : g_link // RULE17
    assign lane_in[g] = links[g].lane; // RULE18
    assign frame_in[g] = links[g].frame;
    assign links[g].ctrl_valid = s_reg.ctrl_valid[g]; // RULE18
    assign links[g].ctrl_word = s_reg.ctrl_word;
  end

  assign rd_data = s_reg.rd_data;
  assign rd_count = s_reg.done_cnt;
  assign active_buf = s_reg.active;
  assign overflow = s_reg.ovf;

  always_comb begin
    int idx;
    logic found;
    logic ovf_set;
    logic [LINK_W-1:0] shifted;
    idx = 0;
    found = 1'b0;
    ovf_set = 1'b0;
    shifted = '0;
    s_next = s_reg;
    wr_en = 1'b0;
    wr_addr = '0;
    wr_data = '0;

    // one held word written per cycle, round robin over the links;
    // nothing is ever asked of the sender, words just arrive
    for (int k = 0; k < NUM_LINKS; k++) begin // RULE10
      idx = int'(s_reg.rr) + k;
      if (idx >= NUM_LINKS) begin
        idx = idx - NUM_LINKS;
      end
      if (!found && s_reg.pend[idx]) begin
        found = 1'b1;
        s_next.pend[idx] = 1'b0;
        s_next.rr = (idx == NUM_LINKS - 1) ? '0 : LINK_ID_W'(idx + 1);
        if (s_reg.wr_cnt == (AW + 1)'(BUF_WORDS)) begin
          ovf_set = 1'b1; // RULE20
        end else begin
          wr_en = 1'b1;
          wr_addr = {s_reg.active, s_reg.wr_cnt[AW-1:0]}; // RULE13
          wr_data = {LINK_ID_W'(idx), s_reg.word[idx]}; // RULE12
          s_next.wr_cnt = s_reg.wr_cnt + 1'b1;
        end
      end
    end

    // deserializer: two bits per beat, lsb first, a whole word per frame
    for (int i = 0; i < NUM_LINKS; i++) begin
      if (frame_in[i]) begin
        shifted = {lane_in[i], s_reg.sh[i][LINK_W-1:LANE_W]}; // RULE11 RULE16
        s_next.sh[i] = shifted;
        s_next.beats[i] = s_reg.beats[i] + 4'd1;
        if (s_reg.beats[i] == 4'(LINK_BEATS - 1)) begin
          s_next.beats[i] = '0;
          if (s_next.pend[i]) begin
            // previous word not yet stored: the new one is lost
            ovf_set = 1'b1; // RULE20
          end else begin
            s_next.pend[i] = 1'b1; // RULE11
            s_next.word[i] = shifted;
          end
        end
      end else begin
        // a frame cut short leaves no partial word behind
        s_next.beats[i] = '0;
      end
    end

    // swap at a clock edge: a word written in this cycle stays in
    // the old buffer and is counted there, so no word is split
    if (swap_tick) begin
      s_next.active = !s_reg.active; // RULE14
      s_next.done_cnt = s_next.wr_cnt; // RULE21
      s_next.wr_cnt = '0; // RULE21
    end

    // the reader gets no stall; it must finish before the next swap
    s_next.rd_data = mem[{!s_reg.active, rd_addr}]; // RULE13

    // a new overflow wins over a clear in the same cycle
    s_next.ovf = (s_reg.ovf && !overflow_clear) || ovf_set; // RULE20

    // control fan-out: one-cycle pulse on the selected aggregator
    s_next.ctrl_valid = '0;
    if (ctrl_wr) begin
      for (int c = 0; c < NUM_LINKS; c++) begin
        if (ctrl_link == LINK_ID_W'(c)) begin
          s_next.ctrl_valid[c] = 1'b1; // RULE18
        end
      end
      s_next.ctrl_word = ctrl_word;
    end

    if (!rst_b) begin
      s_next = '0;
    end
  end

  always_ff @(posedge clock) begin
    s_reg <= s_next;
  end

  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end
endmodule : collector
`default_nettype wire

// *** bench/readout_props.sv ***
// concurrent checks on the aggregator side of the link
`timescale 1ns/10ps
`default_nettype none
module readout_props (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // link signals
  input wire logic [readout_pkg::LANE_W-1:0] lane,
  input wire logic frame,
  input wire logic ctrl_valid,
  input wire logic [readout_pkg::CTRL_W-1:0] ctrl_word,
  // aggregator ports
  input wire logic system_timing_clock,
  input wire logic timestamp_counter_reset,
  input wire logic [readout_pkg::NUM_CONC-1:0] conc_timing_clock,
  input wire logic [readout_pkg::NUM_CONC-1:0] conc_counter_reset,
  input wire logic [readout_pkg::NUM_CONC-1:0] ctrl_path_valid,
  input wire logic [readout_pkg::CTRL_DEST_LSB-1:0] ctrl_path_word
);
  import readout_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic [CTRL_DEST_W-1:0] dest;
  assign dest = ctrl_word[CTRL_W-1:CTRL_DEST_LSB];
  // ten beats of two bits carry one 20-bit word
  sequence word_beats;
    frame [*8] ##1 frame [*2] ##1 !frame;
  endsequence
  sequence pad_beat;
    ##9 (lane[1] == 1'b0);
  endsequence
  frame_len_a: assert property ($rose(frame) |-> word_beats)
    else $error("link frame length wrong");
  pad_bit_a: assert property ($rose(frame) |-> pad_beat)
    else $error("link pad bit set");
  src_range_a: assert property ($rose(frame) ##8 lane[1] |-> ##1 !lane[0])
    else $error("source field out of range");
  clk_fan_a: assert property (conc_timing_clock == {NUM_CONC{system_timing_clock}})
    else $error("timing clock copy differs");
  rst_fan_a: assert property (conc_counter_reset == {NUM_CONC{timestamp_counter_reset}})
    else $error("counter reset copy differs");
  ctrl_route_a: assert property (ctrl_valid && dest < NUM_CONC |=>
    ctrl_path_valid == (6'h01 << $past(dest)))
    else $error("control word on wrong path");
  ctrl_strip_a: assert property (ctrl_valid |=>
    ctrl_path_word == $past(ctrl_word[CTRL_DEST_LSB-1:0]))
    else $error("forwarded control word wrong");
  ctrl_drop_a: assert property (ctrl_valid && dest >= NUM_CONC |=> ctrl_path_valid == '0)
    else $error("bad destination not dropped");
  ctrl_idle_a: assert property (!ctrl_valid |=> ctrl_path_valid == '0)
    else $error("control strobe without cause");
  route_c: cover property (ctrl_valid && dest == 3'h5);
endmodule : readout_props
`default_nettype wire

// *** bench/tb_readout_aggregator_and_collector.sv ***
// self-checking bench: aggregator and collector joined over the link
`timescale 1ns/10ps
`default_nettype none
module tb_readout_aggregator_and_collector;
  import readout_pkg::*;
  localparam int BUFW = 4;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [NUM_CONC-1:0] conc_data = '1;
  logic system_timing_clock = 1'b0;
  logic timestamp_counter_reset = 1'b0;
  logic [NUM_CONC-1:0] conc_timing_clock, conc_counter_reset, ctrl_path_valid;
  logic [CTRL_DEST_LSB-1:0] ctrl_path_word;
  logic swap_tick = 1'b0;
  logic [$clog2(BUFW)-1:0] rd_addr = '0;
  logic [REC_W-1:0] rd_data;
  logic [$clog2(BUFW):0] rd_count;
  logic active_buf, overflow;
  logic overflow_clear = 1'b0;
  logic ctrl_wr = 1'b0;
  logic [LINK_ID_W-1:0] ctrl_link = '0;
  logic [CTRL_W-1:0] ctrl_word = '0;
  logic [DATA_W-1:0] tbl [NUM_CONC] = '{16'hA5C3, 16'h0001, 16'h8000, 16'h7FFE, 16'h5A5A,
    16'hFFFF};
  logic [LINK_W-1:0] sh = '0;
  logic was = 1'b0;
  logic [LINK_W-1:0] mq [$];
  logic exp_buf = 1'b0;
  int fail_count = 0;
  int comparisons = 0;

  always #10 clock = ~clock;

  readout_link_if links [NUM_LINKS] ();
  for (genvar g = 1; g < NUM_LINKS; g++) begin : g_idle
    // spare links held idle so no stray frame is taken
    assign links[g].lane = '0;
    assign links[g].frame = 1'b0;
  end

  aggregator #(.FIFO_WORDS(FIFO_DEPTH)) u_aggregator (.clock(clock), .rst_b(rst_b),
    .conc_data(conc_data), .system_timing_clock(system_timing_clock),
    .timestamp_counter_reset(timestamp_counter_reset), .conc_timing_clock(conc_timing_clock),
    .conc_counter_reset(conc_counter_reset), .ctrl_path_valid(ctrl_path_valid),
    .ctrl_path_word(ctrl_path_word), .link(links[0]));
  collector #(.BUF_WORDS(BUFW)) u_collector (.clock(clock), .rst_b(rst_b),
    .swap_tick(swap_tick), .rd_addr(rd_addr), .rd_data(rd_data), .rd_count(rd_count),
    .active_buf(active_buf), .overflow(overflow), .overflow_clear(overflow_clear),
    .ctrl_wr(ctrl_wr), .ctrl_link(ctrl_link), .ctrl_word(ctrl_word), .links(links));
  readout_props u_readout_props (.clock(clock), .rst_b(rst_b), .lane(links[0].lane),
    .frame(links[0].frame), .ctrl_valid(links[0].ctrl_valid), .ctrl_word(links[0].ctrl_word),
    .system_timing_clock(system_timing_clock), .timestamp_counter_reset(timestamp_counter_reset),
    .conc_timing_clock(conc_timing_clock), .conc_counter_reset(conc_counter_reset),
    .ctrl_path_valid(ctrl_path_valid), .ctrl_path_word(ctrl_path_word));

  // wire monitor: rebuild each link word, lsb pair first
  always @(posedge clock) begin
    if (links[0].frame) sh <= {links[0].lane, sh[LINK_W-1:LANE_W]};
    else if (was) mq.push_back(sh);
    was <= links[0].frame;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic chk_word(input logic [LINK_W-1:0] w, inout logic [NUM_CONC-1:0] seen);
    logic [SRC_W-1:0] s;
    s = w[DATA_W+SRC_W-1:DATA_W];
    chk(32'(w[LINK_W-1]), 0, "pad bit");
    chk(32'(s < NUM_CONC), 1, "source range");
    if (s < NUM_CONC) begin
      chk(32'(w[DATA_W-1:0]), 32'(tbl[s]), "word data");
      seen[s] = 1'b1;
    end
  endtask : chk_word

  task automatic send(input logic [NUM_CONC-1:0] mask);
    logic [IN_STOP_BIT:0] fr;
    for (int s = 0; s <= IN_STOP_BIT; s++) begin
      for (int i = 0; i < NUM_CONC; i++) begin
        fr = {1'b1, tbl[i], 1'b0};
        if (mask[i]) conc_data[i] <= fr[s];
      end
      repeat (IN_BIT_CYCLES) @(posedge clock);
    end
    // time for all queued words to cross the link and land
    repeat (200) @(posedge clock);
  endtask : send

  task automatic swap(input int n, input logic ovf, input logic [NUM_CONC-1:0] want);
    logic [NUM_CONC-1:0] seen;
    seen = '0;
    swap_tick <= 1'b1;
    @(posedge clock);
    swap_tick <= 1'b0;
    exp_buf = ~exp_buf;
    @(negedge clock);
    chk(32'(active_buf), 32'(exp_buf), "active buffer");
    chk(32'(rd_count), n, "words in buffer");
    chk(32'(overflow), 32'(ovf), "overflow flag");
    for (int k = 0; k < n; k++) begin
      @(posedge clock);
      rd_addr <= k[$clog2(BUFW)-1:0];
      @(posedge clock);
      @(negedge clock);
      chk(32'(rd_data[REC_W-1:LINK_W]), 0, "link tag");
      chk_word(rd_data[LINK_W-1:0], seen);
    end
    if (want != '0) chk(32'(seen), 32'(want), "sources stored");
    @(posedge clock);
  endtask : swap

  task automatic ctrl(input logic [CTRL_DEST_W-1:0] d);
    ctrl_word <= {d, 4'hA, 17'h0A5C3 ^ 17'(d)};
    ctrl_wr <= 1'b1;
    @(posedge clock);
    ctrl_wr <= 1'b0;
    // the link strobe stands for the one cycle after the write edge only
    @(negedge clock);
    chk(32'(links[0].ctrl_valid), 1, "link control strobe");
    @(posedge clock);
    @(negedge clock);
    chk(32'(ctrl_path_valid), d < NUM_CONC ? 32'(1) << d : 0, "control path");
    chk(32'(ctrl_path_word), 32'(ctrl_word[CTRL_DEST_LSB-1:0]), "kept fields");
    @(posedge clock);
  endtask : ctrl

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    $display("wrong value at %0t: run did not finish", $time);
    conclude();
  end

  initial begin
    logic [NUM_CONC-1:0] seen;
    seen = '0;
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    @(negedge clock);
    chk(32'(active_buf), 0, "reset buffer");
    chk(32'(overflow), 0, "reset overflow");
    for (int v = 0; v < 4; v++) begin
      @(posedge clock);
      system_timing_clock <= v[0];
      timestamp_counter_reset <= v[1];
      @(negedge clock);
      chk(32'(conc_timing_clock), 32'({NUM_CONC{v[0]}}), "clock copy");
      chk(32'(conc_counter_reset), 32'({NUM_CONC{v[1]}}), "reset copy");
    end
    @(posedge clock);
    for (int d = 0; d < 8; d++) ctrl(3'(d));
    // a word for another aggregator must not reach this one
    ctrl_link <= 4'h1;
    ctrl_wr <= 1'b1;
    @(posedge clock);
    ctrl_wr <= 1'b0;
    @(negedge clock);
    chk(32'(links[1].ctrl_valid), 1, "second link strobe");
    chk(32'(links[0].ctrl_valid), 0, "other link quiet");
    @(posedge clock);
    @(negedge clock);
    chk(32'(ctrl_path_valid), 0, "no path without strobe");
    @(posedge clock);
    send(6'h0F);
    chk(mq.size(), 4, "link words");
    foreach (mq[i]) chk_word(mq[i], seen);
    chk(32'(seen), 32'h0F, "link sources");
    swap(4, 1'b0, 6'h0F);
    send(6'h3F);
    chk(mq.size(), 10, "link words total");
    swap(BUFW, 1'b1, '0);
    overflow_clear <= 1'b1;
    @(posedge clock);
    overflow_clear <= 1'b0;
    @(negedge clock);
    chk(32'(overflow), 0, "overflow cleared");
    @(posedge clock);
    swap(0, 1'b0, '0);
    conclude();
  end
endmodule : tb_readout_aggregator_and_collector
`default_nettype wire
